/* common/pll_ctrl_pkg.sv */
// shared constants, types and field layout for the pll control block
package pll_ctrl_pkg;
  // serial word layout
  localparam int WORD_BITS = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_BITS = 4;
  localparam logic [3:0] ADDR_REF_CTRL = 4'hE;
  localparam logic [3:0] ADDR_FB_GAIN = 4'hF;
  // reference and output control word fields
  localparam int POS_ALL_EN = 27;
  localparam int POS_SLEEP = 26;
  localparam int POS_PUMP_HIZ = 25;
  localparam int POS_PUMP_POL = 24;
  localparam int POS_LOCK_SEL = 20;
  localparam int POS_REF_DIV = 8;
  localparam int REF_DIV_BITS = 12;
  localparam int LOCK_SEL_BITS = 4;
  // feedback and gain word fields
  localparam int POS_GAIN = 30;
  localparam int POS_FB_DIV = 8;
  localparam int FB_DIV_BITS = 18;
  localparam int GAIN_BITS = 2;
  localparam int NUM_OUTPUTS = 4;
  // power-on defaults
  localparam logic [11:0] RST_REF_DIV = 12'h00A;
  localparam logic [17:0] RST_FB_DIV = 18'h002F8;
  localparam logic RST_ALL_EN = 1'b1;
  localparam logic RST_SLEEP = 1'b0;
  localparam logic RST_PUMP_HIZ = 1'b0;
  localparam logic RST_PUMP_POL = 1'b0;
  localparam logic [1:0] RST_GAIN = 2'h0;
  // digital lock detect: window in cycles and good comparisons needed
  localparam logic [7:0] LOCK_WINDOW = 8'h04;
  localparam logic [3:0] LOCK_COUNT = 4'h8;
  // lock pin selector codes
  typedef enum logic [3:0] {
    LOCK_HIZ = 4'b0000,
    LOCK_HIGH = 4'b0001,
    LOCK_LOW = 4'b0010,
    LOCK_DIG_HI = 4'b0011,
    LOCK_DIG_LO = 4'b0100,
    LOCK_ANA_PP = 4'b0101,
    LOCK_ANA_NMOS = 4'b0110,
    LOCK_ANA_PMOS = 4'b0111,
    LOCK_FB_HALF = 4'b1001,
    LOCK_REF_DIV = 4'b1011
  } lock_mode_e;
  // pump gain multipliers
  localparam logic [5:0] GAIN_X1 = 6'h01;
  localparam logic [5:0] GAIN_X4 = 6'h04;
  localparam logic [5:0] GAIN_X16 = 6'h10;
  localparam logic [5:0] GAIN_X32 = 6'h20;
  // latched configuration
  typedef struct packed {
    logic all_outputs_enable;
    logic device_sleep_bit;
    logic pump_high_impedance;
    logic pump_polarity;
    logic [3:0] lock_select;
    logic [11:0] ref_divide;
    logic [1:0] pump_gain_select;
    logic [17:0] fb_divide;
  } pll_cfg_s;
  localparam pll_cfg_s CFG_RESET = '{
    all_outputs_enable: RST_ALL_EN,
    device_sleep_bit: RST_SLEEP,
    pump_high_impedance: RST_PUMP_HIZ,
    pump_polarity: RST_PUMP_POL,
    lock_select: LOCK_HIZ,
    ref_divide: RST_REF_DIV,
    pump_gain_select: RST_GAIN,
    fb_divide: RST_FB_DIV
  };
endpackage

/* dv/host_model.sv */
// host side model that drives the serial configuration pins
`timescale 1ns/1ps
module host_model (
  // pacing clock
  input wire logic clk_sys,
  // serial pins toward the device
  output logic cfg_clk,
  output logic cfg_data,
  output logic cfg_latch
);
  // cycles per pin level; 3 is the fastest the device accepts
  int pace = 4;
  initial
  begin
    cfg_clk = 1'b0;
    cfg_data = 1'b0;
    cfg_latch = 1'b0;
  end
  task automatic hold();
    repeat (pace) @(negedge clk_sys);
  endtask
  // whole 32-bit word msb first, address nibble last
  task automatic shift_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      cfg_data = w[i];
      hold();
      cfg_clk = 1'b1;
      hold();
      cfg_clk = 1'b0;
    end
    // released data line must not keep showing the last bit
    cfg_data = ~w[0];
  endtask
  // strobe that commits the shifted word
  task automatic latch_word();
    hold();
    cfg_latch = 1'b1;
    hold();
    cfg_latch = 1'b0;
    hold();
  endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the pll control block
`timescale 1ns/1ps
module tb_top;
  import pll_ctrl_pkg::*;
  typedef struct packed {
    logic cnt;
    logic [14:0] mask;
    logic [14:0] val;
  } note_s;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_clk, cfg_data, cfg_latch;
  logic ref_clk = 1'b0;
  logic pre_clk = 1'b0;
  logic analog = 1'b0;
  logic oe_pin = 1'b1;
  logic [NUM_OUTPUTS-1:0] per = '0;
  logic ld_o, ld_oe, up, dn, pen, slp, locked, ld_q;
  logic [5:0] gf;
  logic [NUM_OUTPUTS-1:0] ce;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 59975;
  int cycles = 0;
  int n_up = 0;
  int n_dn = 0;
  int n_rise = 0;
  note_s notes[$];
  note_s cur;
  logic all_en, sleep, hiz, pol;
  logic [3:0] sel;
  logic [1:0] gain;
  logic [11:0] rdiv;
  logic [17:0] ndiv;
  logic [31:0] w;
  logic lock_exp = 1'b0;
  logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0};

  always #2.5 clk_sys = ~clk_sys;

  pll_ctrl u_pll_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
    .cfg_clk(cfg_clk), .cfg_data(cfg_data), .cfg_latch(cfg_latch),
    .reference_clock_input(ref_clk), .prescaler_clock(pre_clk),
    .analog_lock_in(analog), .output_enable_pin(oe_pin),
    .per_output_enable(per), .lock_indicator_pin_o(ld_o),
    .lock_indicator_pin_oe(ld_oe), .pump_up(up), .pump_down(dn),
    .pump_output_enable(pen), .pump_gain_factor(gf),
    .clk_out_enable(ce), .device_sleep(slp), .pll_locked(locked));
  host_model u_host_model (.clk_sys(clk_sys), .cfg_clk(cfg_clk),
    .cfg_data(cfg_data), .cfg_latch(cfg_latch));

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_lvl(input logic [14:0] e, m, g);
    comparisons++;
    if ((g & m) !== (e & m))
    begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask
  task automatic cmp_cnt(input logic [14:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic [31:0] ref_word();
    logic [31:0] r;
    r = '0;
    r[POS_ALL_EN] = all_en;
    r[POS_SLEEP] = sleep;
    r[POS_PUMP_HIZ] = hiz;
    r[POS_PUMP_POL] = pol;
    r[POS_LOCK_SEL +: LOCK_SEL_BITS] = sel;
    r[POS_REF_DIV +: REF_DIV_BITS] = rdiv;
    r[ADDR_LSB +: ADDR_BITS] = ADDR_REF_CTRL;
    return r;
  endfunction
  function automatic logic [31:0] fb_word();
    logic [31:0] r;
    r = '0;
    r[POS_GAIN +: GAIN_BITS] = gain;
    r[POS_FB_DIV +: FB_DIV_BITS] = ndiv;
    r[ADDR_LSB +: ADDR_BITS] = ADDR_FB_GAIN;
    return r;
  endfunction
  // note the expected pin levels, then let the monitor settle them
  task automatic expect_lvl();
    note_s n;
    logic [1:0] pin;
    logic [1:0] pm;
    logic [5:0] g;
    pm = 2'b11;
    pin = 2'b01;
    case (sel)
      4'h1: pin = 2'b11;
      4'h2: pin = 2'b01;
      4'h3: pin = {lock_exp, 1'b1};
      4'h4: pin = {~lock_exp, 1'b1};
      4'h5: pin = {analog, 1'b1};
      4'h6: pin = analog ? 2'b00 : 2'b01;
      4'h7: pin = analog ? 2'b11 : 2'b00;
      4'h9, 4'hB: pm = 2'b01;
      default: pin = 2'b00;
    endcase
    if (sleep)
      pin = 2'b00;
    if (pin[0] == 1'b0)
      pm = 2'b01;
    case (gain)
      2'h0: g = GAIN_X1;
      2'h1: g = GAIN_X4;
      2'h2: g = GAIN_X16;
      default: g = GAIN_X32;
    endcase
    n.cnt = 1'b0;
    n.val = {lock_exp, pin, ~hiz & ~sleep, sleep,
      (all_en & oe_pin & ~sleep) ? per : 4'h0, g};
    n.mask = {1'b1, pm, 6'h3F, sleep ? 6'h00 : 6'h3F};
    notes.push_back(n);
    while (notes.size() != 0)
      @(negedge clk_sys);
  endtask
  task automatic expect_cnt(input logic [3:0] u, d, r);
    note_s n;
    n.cnt = 1'b1;
    n.mask = '1;
    n.val = {3'b000, u, d, r};
    notes.push_back(n);
    while (notes.size() != 0)
      @(negedge clk_sys);
  endtask
  task automatic wr(input logic [31:0] v);
    u_host_model.shift_word(v);
    u_host_model.latch_word();
    expect_lvl();
  endtask
  // both input clocks stay well below a sixth of the system clock
  task automatic run_clocks(input int nr, input int np);
    fork
      repeat (nr)
      begin
        repeat (4) @(negedge clk_sys);
        ref_clk = 1'b1;
        repeat (4) @(negedge clk_sys);
        ref_clk = 1'b0;
      end
      repeat (np)
      begin
        repeat (5) @(negedge clk_sys);
        pre_clk = 1'b1;
        repeat (5) @(negedge clk_sys);
        pre_clk = 1'b0;
      end
    join
  endtask

  // pulse counting off the falling edge, plus the hang limit
  always @(negedge clk_sys)
  begin
    n_up += int'(up === 1'b1);
    n_dn += int'(dn === 1'b1);
    n_rise += int'(ld_o === 1'b1 && ld_q === 1'b0);
    ld_q = ld_o;
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  // monitor: oldest note against settled outputs, counts restart
  // sampled on the falling edge, well away from the launching edge
  always
  begin
    @(negedge clk_sys);
    if (notes.size() != 0)
    begin
      repeat (8) @(negedge clk_sys);
      cur = notes[0];
      if (cur.cnt)
        cmp_cnt(cur.val, {3'b000, n_up[3:0], n_dn[3:0], n_rise[3:0]});
      else
        cmp_lvl(cur.val, cur.mask, {locked, ld_o, ld_oe, pen, slp, ce, gf});
      n_up = 0;
      n_dn = 0;
      n_rise = 0;
      void'(notes.pop_front());
    end
  end

  initial
  begin
    all_en = RST_ALL_EN;
    sleep = RST_SLEEP;
    hiz = RST_PUMP_HIZ;
    pol = RST_PUMP_POL;
    sel = LOCK_HIZ;
    gain = RST_GAIN;
    rdiv = RST_REF_DIV;
    ndiv = RST_FB_DIV;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    expect_lvl();
    // valid selector codes only; 8, 10 and 12-15 never sent
    foreach (codes[i])
    begin
      analog = 1'($random(seed));
      sel = codes[i];
      wr(ref_word());
    end
    // shifted word must not act before its strobe
    sel = 4'h1;
    w = ref_word();
    sel = 4'h0;
    u_host_model.shift_word(w);
    expect_lvl();
    sel = 4'h1;
    u_host_model.latch_word();
    expect_lvl();
    // unmapped address is ignored
    w[POS_SLEEP] = 1'b1;
    w[ADDR_LSB +: ADDR_BITS] = 4'h3;
    wr(w);
    u_host_model.pace = 3;
    for (int i = 0; i < 4; i++)
    begin
      gain = 2'(i);
      ndiv = 18'($random(seed)) | 18'h00001;
      wr(fb_word());
    end
    u_host_model.pace = 4;
    sel = 4'h0;
    for (int i = 0; i < 6; i++)
    begin
      per = 4'($random(seed));
      all_en = i[0];
      oe_pin = (i != 5);
      wr(ref_word());
    end
    sleep = 1'b1;
    sel = 4'h1;
    wr(ref_word());
    sleep = 1'b0;
    hiz = 1'b1;
    wr(ref_word());
    hiz = 1'b0;
    // negative polarity suits a falling tuning slope
    pol = 1'b0;
    rdiv = 12'h003;
    sel = LOCK_REF_DIV;
    wr(ref_word());
    ndiv = 18'h00005;
    gain = 2'h2;
    wr(fb_word());
    run_clocks(12, 10);
    expect_cnt(4'h2, 4'h4, 4'h4);
    pol = 1'b1;
    sel = LOCK_FB_HALF;
    wr(ref_word());
    run_clocks(12, 20);
    expect_cnt(4'h4, 4'h4, 4'h2);
    // equal tick rates, feedback tick one cycle behind the reference tick
    rdiv = 12'h005;
    sel = LOCK_DIG_HI;
    wr(ref_word());
    ndiv = 18'h00004;
    wr(fb_word());
    run_clocks(4, 3);
    run_clocks(40, 32);
    expect_cnt(4'h8, 4'h8, 4'h1);
    lock_exp = 1'b1;
    expect_lvl();
    // zero reference ratio stops its ticks, so lock is lost
    rdiv = 12'h000;
    wr(ref_word());
    run_clocks(10, 8);
    lock_exp = 1'b0;
    expect_cnt(4'h0, 4'h2, 4'h0);
    expect_lvl();
    summarize();
  end
endmodule

/* hw/edge_divider.sv */
// programmable divider counting enable pulses, with tick and half-phase
`timescale 1ns/1ps
module edge_divider #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // input edge pulse and ratio
  input wire logic step,
  input wire logic [WIDTH-1:0] ratio,
  // outputs
  output logic tick,
  output logic high_half
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic wrap;
  logic [WIDTH-1:0] low_len;

  // zero ratio is invalid: the counter idles and never ticks
  always_comb
  begin
    wrap = (ratio != '0) && (count >= ratio - 1'b1);
    next_count = wrap || (ratio == '0) ? '0 : count + 1'b1;
    low_len = ratio >> 1;
  end

  // count edges; odd ratios give the extra edge to the high phase
  // low phase starts at count zero, so the first period after reset is full
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      tick <= 1'b0;
      high_half <= 1'b0;
    end
    else
    begin
      tick <= step && wrap;
      if (step)
      begin
        count <= next_count;
        high_half <= (ratio != '0) && (next_count >= low_len);
      end
    end
  end
endmodule

/* hw/pll_ctrl.sv */
// pll divider, lock pin and charge pump control behind the serial port
`timescale 1ns/1ps
module pll_ctrl
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial configuration pins
  input wire logic cfg_clk,
  input wire logic cfg_data,
  input wire logic cfg_latch,
  // clocks and analog lock from the pll core
  input wire logic reference_clock_input,
  input wire logic prescaler_clock,
  input wire logic analog_lock_in,
  // output enable controls
  input wire logic output_enable_pin,
  input wire logic [NUM_OUTPUTS-1:0] per_output_enable,
  // lock indicator pin
  output logic lock_indicator_pin_o,
  output logic lock_indicator_pin_oe,
  // charge pump controls
  output logic pump_up,
  output logic pump_down,
  output logic pump_output_enable,
  output logic [5:0] pump_gain_factor,
  // clock output gating and status
  output logic [NUM_OUTPUTS-1:0] clk_out_enable,
  output logic device_sleep,
  output logic pll_locked
);
  logic [6:0] pins_sync;
  logic s_clk, s_data, s_latch, s_ref, s_presc, s_ana, s_goe;
  logic s_clk_d, s_latch_d, s_ref_d, s_presc_d;
  logic clk_rise, latch_rise, ref_rise, presc_rise;
  logic [WORD_BITS-1:0] shift_word;
  pll_cfg_s cfg;
  logic sleep;
  logic r_tick, r_high, n_tick, n_half;
  logic [7:0] r_age;
  logic [3:0] good_count;
  logic next_pin_o, next_pin_oe;

  // every pin input except per_output_enable passes through the synchroniser
  sync_2ff #(.WIDTH(7)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({cfg_clk, cfg_data, cfg_latch, reference_clock_input,
      prescaler_clock, analog_lock_in, output_enable_pin}),
    .sync_out(pins_sync)
  );
  assign {s_clk, s_data, s_latch, s_ref, s_presc, s_ana, s_goe} = pins_sync;

  // edge history of the synchronised levels
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_clk_d <= 1'b0;
      s_latch_d <= 1'b0;
      s_ref_d <= 1'b0;
      s_presc_d <= 1'b0;
    end
    else
    begin
      s_clk_d <= s_clk;
      s_latch_d <= s_latch;
      s_ref_d <= s_ref;
      s_presc_d <= s_presc;
    end
  end

  // sleep freezes both dividers so nothing toggles
  assign sleep = cfg.device_sleep_bit;
  assign clk_rise = s_clk && !s_clk_d;
  assign latch_rise = s_latch && !s_latch_d;
  assign ref_rise = s_ref && !s_ref_d && !sleep;
  assign presc_rise = s_presc && !s_presc_d && !sleep;

  // serial shift register, msb first, separate from the live settings
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      shift_word <= '0;
    else if (clk_rise)
      shift_word <= {shift_word[WORD_BITS-2:0], s_data};
  end

  // settings change only on the latch strobe, never mid-shift
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cfg <= CFG_RESET;
    else if (latch_rise)
    begin
      unique case (shift_word[ADDR_LSB +: ADDR_BITS])
        ADDR_REF_CTRL:
        begin
          cfg.all_outputs_enable <= shift_word[POS_ALL_EN];
          cfg.device_sleep_bit <= shift_word[POS_SLEEP];
          cfg.pump_high_impedance <= shift_word[POS_PUMP_HIZ];
          cfg.pump_polarity <= shift_word[POS_PUMP_POL];
          cfg.lock_select <= shift_word[POS_LOCK_SEL +: LOCK_SEL_BITS];
          cfg.ref_divide <= shift_word[POS_REF_DIV +: REF_DIV_BITS];
        end
        ADDR_FB_GAIN:
        begin
          cfg.pump_gain_select <= shift_word[POS_GAIN +: GAIN_BITS];
          cfg.fb_divide <= shift_word[POS_FB_DIV +: FB_DIV_BITS];
        end
        default:
        begin
          cfg <= cfg;
        end
      endcase
    end
  end

  // reference divider on reference clock edges
  edge_divider #(.WIDTH(REF_DIV_BITS)) u_ref_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .step(ref_rise),
    .ratio(cfg.ref_divide),
    .tick(r_tick),
    .high_half(r_high)
  );

  // feedback divider counts prescaler edges, ticks go to the detector
  edge_divider #(.WIDTH(FB_DIV_BITS)) u_fb_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .step(presc_rise),
    .ratio(cfg.fb_divide),
    .tick(n_tick),
    .high_half() // code 9 halves the tick instead
  );

  // halved feedback output: toggles once per feedback tick
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      n_half <= 1'b0;
    else if (sleep)
      n_half <= 1'b0;
    else if (n_tick)
      n_half <= !n_half;
  end

  // digital lock: feedback tick must land within the window of the
  // reference tick several times in a row; a miss restarts the count
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_age <= 8'hFF;
      good_count <= '0;
    end
    else if (sleep)
    begin
      r_age <= 8'hFF;
      good_count <= '0;
    end
    else
    begin
      if (r_tick)
        r_age <= '0;
      else if (r_age != 8'hFF)
        r_age <= r_age + 8'h01;
      if (n_tick)
      begin
        if (r_tick || r_age <= LOCK_WINDOW)
        begin
          if (good_count != LOCK_COUNT)
            good_count <= good_count + 4'h1;
        end
        else
          good_count <= '0;
      end
    end
  end
  assign pll_locked = (good_count == LOCK_COUNT);

  // lock pin selector; unused codes fall back to high impedance
  always_comb
  begin
    next_pin_o = 1'b0;
    next_pin_oe = 1'b0;
    unique case (cfg.lock_select)
      LOCK_HIZ:
      begin
        next_pin_oe = 1'b0;
      end
      LOCK_HIGH:
      begin
        next_pin_o = 1'b1;
        next_pin_oe = 1'b1;
      end
      LOCK_LOW:
      begin
        next_pin_oe = 1'b1;
      end
      LOCK_DIG_HI:
      begin
        next_pin_o = pll_locked;
        next_pin_oe = 1'b1;
      end
      LOCK_DIG_LO:
      begin
        next_pin_o = !pll_locked;
        next_pin_oe = 1'b1;
      end
      LOCK_ANA_PP:
      begin
        next_pin_o = s_ana;
        next_pin_oe = 1'b1;
      end
      LOCK_ANA_NMOS:
      begin
        next_pin_oe = !s_ana; // pulls low while unlocked
      end
      LOCK_ANA_PMOS:
      begin
        next_pin_o = 1'b1;
        next_pin_oe = s_ana; // pulls high while locked
      end
      LOCK_FB_HALF:
      begin
        next_pin_o = n_half;
        next_pin_oe = 1'b1;
      end
      LOCK_REF_DIV:
      begin
        next_pin_o = r_high;
        next_pin_oe = 1'b1;
      end
      default:
      begin
        next_pin_oe = 1'b0;
      end
    endcase
    if (sleep)
      next_pin_oe = 1'b0;
  end

  // registered pin drive keeps glitches off the pad
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_indicator_pin_o <= 1'b0;
      lock_indicator_pin_oe <= 1'b0;
    end
    else
    begin
      lock_indicator_pin_o <= next_pin_o;
      lock_indicator_pin_oe <= next_pin_oe;
    end
  end

  // bang-bang charge pump pulses; polarity swaps the directions
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_output_enable <= 1'b0;
    end
    else
    begin
      pump_up <= cfg.pump_polarity ? r_tick : n_tick;
      pump_down <= cfg.pump_polarity ? n_tick : r_tick;
      pump_output_enable <= !cfg.pump_high_impedance && !sleep;
    end
  end

  // gain code to multiplier
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pump_gain_factor <= GAIN_X1;
    else
    begin
      unique case (cfg.pump_gain_select)
        2'h0: pump_gain_factor <= GAIN_X1;
        2'h1: pump_gain_factor <= GAIN_X4;
        2'h2: pump_gain_factor <= GAIN_X16;
        2'h3: pump_gain_factor <= GAIN_X32;
      endcase
    end
  end

  // output gating: global bit and pin override each per-output bit
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_out_enable <= '0;
      device_sleep <= 1'b0;
    end
    else
    begin
      clk_out_enable <= (cfg.all_outputs_enable && s_goe && !sleep) ?
        per_output_enable : '0;
      device_sleep <= sleep;
    end
  end

  // settings never move except right after a latch strobe
  property p_cfg_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    (cfg != $past(cfg)) |-> $past(latch_rise);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings changed without a latch strobe");

  property p_sleep_outputs;
    @(posedge clk_sys) disable iff (!reset_n)
    sleep ##1 sleep |-> !lock_indicator_pin_oe && !pump_output_enable
      && clk_out_enable == '0;
  endproperty
  a_sleep_outputs: assert property (p_sleep_outputs)
    else $error("a block stayed active while asleep");

  property p_global_off;
    @(posedge clk_sys) disable iff (!reset_n)
    !cfg.all_outputs_enable |=> clk_out_enable == '0;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("clock output on with global enable low");

  property p_per_output;
    @(posedge clk_sys) disable iff (!reset_n)
    cfg.all_outputs_enable && s_goe && !sleep
      |=> clk_out_enable == $past(per_output_enable);
  endproperty
  a_per_output: assert property (p_per_output)
    else $error("per-output enable not followed");

  property p_pump_hiz;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(cfg.pump_high_impedance) |=> !pump_output_enable;
  endproperty
  a_pump_hiz: assert property (p_pump_hiz)
    else $error("pump still driving in high impedance");

  property p_polarity;
    @(posedge clk_sys) disable iff (!reset_n)
    r_tick && !n_tick && $stable(cfg.pump_polarity)
      |=> (pump_up == $past(cfg.pump_polarity)) && (pump_down != pump_up);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pump direction wrong for polarity");

  property p_gain;
    @(posedge clk_sys) disable iff (!reset_n)
    cfg.pump_gain_select == 2'h2 ##1 cfg.pump_gain_select == 2'h2
      |-> pump_gain_factor == GAIN_X16;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code 2 not 16x");

  property p_lock_high;
    @(posedge clk_sys) disable iff (!reset_n)
    cfg.lock_select == LOCK_HIGH && !sleep
      |=> lock_indicator_pin_oe && lock_indicator_pin_o;
  endproperty
  a_lock_high: assert property (p_lock_high)
    else $error("lock pin not driven high");

  property p_fb_half;
    @(posedge clk_sys) disable iff (!reset_n)
    n_tick && !sleep |=> n_half != $past(n_half);
  endproperty
  a_fb_half: assert property (p_fb_half)
    else $error("halved feedback output missed a toggle");

  property p_zero_ratio;
    @(posedge clk_sys) disable iff (!reset_n)
    cfg.ref_divide == '0 ##1 cfg.ref_divide == '0 |-> !r_tick;
  endproperty
  a_zero_ratio: assert property (p_zero_ratio)
    else $error("reference divider ticked with zero ratio");
endmodule

/* hw/sync_2ff.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // pins in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
